/* dv/qsph_spi_peer.sv */
module qsph_spi_peer (
    input  wire logic        i_sck,
    input  wire logic        i_cs_n,
    input  wire logic        i_mosi,
    input  wire logic        i_cpol,
    input  wire logic        i_cpha,
    input  wire logic [5:0]  i_bits,
    input  wire logic [31:0] i_seed,
    output logic             o_miso,
    output logic [31:0]      o_got
);
    timeunit 1ns;
    timeprecision 100ps;
    int   cnt = 0;
    logic b;
    initial o_got = '0;
    assign b = i_seed[5'(i_cpha ? 32 - cnt : 31 - cnt)];
    // released line shows the inverse so a stale bit never passes as data
    assign o_miso = i_cs_n ? ~b : b;
    always @(negedge i_cs_n) cnt = 0;
    always @(i_sck) begin
        if (!i_cs_n) begin
            if ((i_sck != i_cpol) ^ i_cpha) begin
                o_got = {o_got[30:0], i_mosi};
            end else begin
                cnt = i_cpha ? cnt % i_bits + 1 : (cnt + 1) % i_bits;
            end
        end
    end
endmodule

/* dv/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst_n = 0, en_wr = 0, en_val = 1, sw_wr = 0, cfg_wr = 0;
    logic        prot = 0, dbg = 0, cpol = 0, cpha = 0, tx_v = 0, rd = 0, eclr = 0, cclr = 0;
    logic        mem = 0, a32 = 0, xr = 0, xrdy, xv;
    logic [1:0]  len = qsph_pkg::LEN_8;
    logic [7:0]  baud = 8'h01, dly = 8'h00;
    logic [31:0] tx_d = '0, seed = '0, xa = '0, rxd, got, xd;
    logic [31:0] q[$];
    logic [3:0]  dout, din, oe;
    logic        miso, sck, cs_n, enb, swb, txr, tef, tcf, rff, ovf, tdr, rdr;
    int          error_cnt = 0, checks_done = 0, cyc = 0, bits = 8, n;
    assign din = {~dout[3:2], miso, dout[0]};
    qsph_top u_qsph_top (.i_clock(clk), .i_rst_n(rst_n), .i_enable_wr(en_wr),
        .i_enable_val(en_val), .i_software_reset_bit_wr(sw_wr), .o_enabled(enb), .o_software_reset_bit(swb),
        .i_cfg_wr(cfg_wr), .i_protect_on(prot), .i_debugger_access(dbg), .i_mem_mode(mem),
        .i_addr32(a32), .i_word_len(len), .i_lanes(qsph_pkg::LANE_1), .i_cpol(cpol),
        .i_cpha(cpha), .i_baud_div(baud), .i_inter_transfer_delay(dly),
        .i_clock_start_delay(dly), .i_select_inactive_delay(dly), .i_tx_valid(tx_v),
        .i_tx_data(tx_d), .o_tx_ready(txr), .o_rx_data(rxd), .i_rx_read(rd), .i_error_clr(eclr),
        .i_complete_clr(cclr), .o_transmit_empty_flag(tef), .o_transmit_complete_flag(tcf),
        .o_receive_full_flag(rff), .o_overrun_flag(ovf), .o_tx_dma_req(tdr), .o_rx_dma_req(rdr),
        .i_xip_req(xr), .i_xip_addr(xa), .i_xip_instr(xa[7:0]), .o_xip_ready(xrdy),
        .o_xip_data(xd), .o_xip_valid(xv), .o_sck(sck), .o_cs_n(cs_n), .i_dio(din), .o_dio(dout),
        .o_dio_oe_n(oe));
    qsph_spi_peer u_qsph_spi_peer (.i_sck(sck), .i_cs_n(cs_n), .i_mosi(dout[0]), .i_cpol(cpol),
        .i_cpha(cpha), .i_bits(6'(bits)), .i_seed(seed), .o_miso(miso), .o_got(got));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask
    // bounded wait; a hang shows up as a failed compare afterwards
    task automatic wait_for(ref logic s);
        for (n = 0; n < 9000 && s !== 1'b1; n++) @(negedge clk);
        chk(s, 1);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one clock only: double rate is never selected
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cyc == 40000) begin
        error_cnt++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hf060));
        repeat (4) @(negedge clk);
        rst_n = 1;
        chk({enb, cs_n, sck, tef, tcf, rff, ovf, txr}, 8'hc1);
        for (int m = 0; m < 12; m++) begin
            {cpol, cpha} = 2'(m);
            len = 2'(m / 4);
            bits = 8 << len;
            baud = 8'(1 + $urandom % 3);
            dly = 8'($urandom % 4);
            seed = $urandom;
            pulse(cfg_wr);
            repeat (2) @(negedge clk);
            chk(sck, cpol);
            repeat (2) begin
                tx_d = $urandom | ~32'((64'h1 << bits) - 1);
                q.push_back(tx_d);
                tx_v = 1;
                @(negedge clk);
            end
            tx_v = 0;
            wait_for(rff);
            chk({rdr, rxd}, {1'b1, seed >> (32 - bits)});
            wait_for(ovf);
            chk(rxd, seed >> (32 - bits));
            wait_for(tcf);
            chk({cs_n, tef, tdr}, 3'h7);
            chk(got & 32'((64'h1 << bits) - 1), q[$] & 32'((64'h1 << bits) - 1));
            pulse(rd);
            chk(rff, 0);
            pulse(eclr);
            pulse(cclr);
        end
        en_val = 0;
        pulse(en_wr);
        chk({enb, txr}, 2'b00);
        en_val = 1;
        @(negedge clk);
        pulse(en_wr);
        chk({enb, txr}, 2'b11);
        len = qsph_pkg::LEN_32;
        baud = 8'h08;
        pulse(cfg_wr);
        tx_v = 1;
        for (n = 0; n < 20 && txr === 1'b1; n++) @(negedge clk);
        tx_v = 0;
        // stored words, the output register and the shifter
        chk(n, qsph_pkg::FIFO_DEPTH + 2);
        wait_for(tcf);
        chk(tef, 1);
        chk({got, rxd}, {tx_d, seed});
        prot = 1;
        {cpol, cpha} = 2'b00;
        pulse(cfg_wr);
        repeat (2) @(negedge clk);
        chk(sck, 1);
        dbg = 1;
        pulse(cfg_wr);
        repeat (2) @(negedge clk);
        chk(sck, 0);
        {prot, dbg, cpol} = 3'b001;
        pulse(cfg_wr);
        repeat (2) @(negedge clk);
        pulse(sw_wr);
        chk({swb, sck}, 2'b11);
        @(negedge clk);
        chk({swb, enb, sck}, 3'b010);
        mem = 1;
        for (int a = 0; a < 2; a++) begin
            a32 = 1'(a);
            bits = a ? 20 : 16;
            seed = $urandom;
            xa = $urandom;
            pulse(cfg_wr);
            repeat (2) @(negedge clk);
            chk({xrdy, oe}, 5'h1e);
            xr = 1;
            wait_for(xv);
            xr = 0;
            chk(xd, ((seed >> (32 - bits)) << (32 - bits)) | (seed >> bits));
        end
        wrap_up();
    end
endmodule

/* hdl/qsph_fifo.sv */
module qsph_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic    i_clock,
    input wire logic    i_rst_n,
    qsph_fifo_if.store  f
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    // depth must be a power of two: pointers wrap freely
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic [WIDTH-1:0]            dout;
        logic                        dv;
    } qsph_fifo_st_t;
    qsph_fifo_st_t s;
    qsph_fifo_st_t next_s;
    logic          push;
    logic          ld;

    assign f.push_ready = s.cnt < (AW+1)'(DEPTH);
    assign f.pop_valid  = s.dv;
    assign f.pop_data   = s.dout;

    always_comb begin
        next_s = s;
        push   = f.push_valid && f.push_ready;
        ld     = 1'b0;
        if (f.clear) begin
            next_s = '0;
        end else begin
            if (f.pop_ready && s.dv) begin
                next_s.dv = 1'b0;
            end
            if (push) begin
                next_s.mem[s.wp] = f.push_data;
                next_s.wp        = s.wp + 1'b1;
            end
            // read data leave through a register
            if (!next_s.dv && s.cnt != '0) begin
                ld          = 1'b1;
                next_s.dout = s.mem[s.rp];
                next_s.dv   = 1'b1;
                next_s.rp   = s.rp + 1'b1;
            end
            next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(ld);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

/* hdl/qsph_top.sv */
// Operation
// - drive clock and select; one, two or four data lanes, two-way beyond one; plain mode words shift on one lane whatever the lane setting
// - plain mode words are 8, 16 or 32 bits long
// - memory addresses are 24 bits, or 32 bits when extended addressing is chosen
// - always the host; every transfer is started here
// - next word waits while current shifts; received word goes to holding register
// - enabled straight after power-on reset
// - enable write of one enables, of zero disables
// - software reset write returns everything to reset state
// - single data rate by default, no fast clock needed
// - serial clock is module clock divided by twice the divider of 1 to 255, so by 2 to 510
// - keeps running while the processor is halted by a debugger
// - runs in sleep with its clock; flags can serve as wake requests
// - configuration writes may be protected; control, data, flags never are
// - debugger accesses bypass write protection
// - one dma request for receive, one for transmit
// - programmable gap, select-to-clock delay and least select inactive time
// - clock polarity and phase chosen by software
// - memory mode reads flash directly for execute-in-place fetches
// - four clock modes fix shift edge, capture edge and idle level
// - word into shifter sets transmit empty and dma request; write clears it
// - transmit complete set at end, after the inter-transfer delay if any
// - receive full on landing, cleared on read; overrun if unread
module qsph_top (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_enable_wr,
    input  wire logic        i_enable_val,
    input  wire logic        i_software_reset_bit_wr,
    output logic             o_enabled,
    output logic             o_software_reset_bit,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_protect_on,
    input  wire logic        i_debugger_access,
    input  wire logic        i_mem_mode,
    input  wire logic        i_addr32,
    input  wire logic [1:0]  i_word_len,
    input  wire logic [1:0]  i_lanes,
    input  wire logic        i_cpol,
    input  wire logic        i_cpha,
    input  wire logic [7:0]  i_baud_div,
    input  wire logic [7:0]  i_inter_transfer_delay,
    input  wire logic [7:0]  i_clock_start_delay,
    input  wire logic [7:0]  i_select_inactive_delay,
    input  wire logic        i_tx_valid,
    input  wire logic [31:0] i_tx_data,
    output logic             o_tx_ready,
    output logic [31:0]      o_rx_data,
    input  wire logic        i_rx_read,
    input  wire logic        i_error_clr,
    input  wire logic        i_complete_clr,
    output logic             o_transmit_empty_flag,
    output logic             o_transmit_complete_flag,
    output logic             o_receive_full_flag,
    output logic             o_overrun_flag,
    output logic             o_tx_dma_req,
    output logic             o_rx_dma_req,
    input  wire logic        i_xip_req,
    input  wire logic [31:0] i_xip_addr,
    input  wire logic [7:0]  i_xip_instr,
    output logic             o_xip_ready,
    output logic [31:0]      o_xip_data,
    output logic             o_xip_valid,
    output logic             o_sck,
    output logic             o_cs_n,
    input  wire logic [3:0]  i_dio,
    output logic [3:0]       o_dio,
    output logic [3:0]       o_dio_oe_n
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        qsph_pkg::qsph_state_t st;
        logic [1:0]            seg;
        logic [31:0]           sh;
        logic [31:0]           rx;
        logic [31:0]           rxd;
        logic [31:0]           xipd;
        logic [6:0]            hcnt;
        logic [7:0]            div;
        logic [7:0]            dly;
        logic [7:0]            csi;
        logic                  sck;
        logic                  cs_n;
        logic                  en;
        logic                  software_reset_bit;
        logic                  rx_full;
        logic                  ovr;
        logic                  tx_empty;
        logic                  tx_done;
        logic                  xipv;
        logic [1:0]            len;
        logic [1:0]            lanes;
        logic                  mem;
        logic                  a32;
        logic                  cpol;
        logic                  cpha;
        logic [7:0]            baud;
        logic [7:0]            bct;
        logic [7:0]            bs;
        logic [7:0]            dcs;
    } qsph_top_st_t;

    localparam qsph_top_st_t S_RST = '{
        st:      qsph_pkg::st_idle,
        seg:     qsph_pkg::SEG_SPI,
        csi:     qsph_pkg::CSI_MAX,
        cs_n:    1'b1,
        en:      qsph_pkg::RST_EN,
        baud:    qsph_pkg::RST_BAUD,
        default: '0
    };

    qsph_top_st_t s;
    qsph_top_st_t next_s;

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    function automatic logic [5:0] len_bits(input logic [1:0] len);
        case (len)
            qsph_pkg::LEN_8:  len_bits = qsph_pkg::BITS_8;
            qsph_pkg::LEN_16: len_bits = qsph_pkg::BITS_16;
            default:          len_bits = qsph_pkg::BITS_32;
        endcase
    endfunction

    function automatic logic [2:0] seg_w(input logic [1:0] seg, input logic [1:0] lanes);
        if (seg == qsph_pkg::SEG_SPI || seg == qsph_pkg::SEG_INSTR) begin
            seg_w = 3'h1;
        end else if (lanes == qsph_pkg::LANE_2) begin
            seg_w = 3'h2;
        end else if (lanes == qsph_pkg::LANE_4) begin
            seg_w = 3'h4;
        end else begin
            seg_w = 3'h1;
        end
    endfunction

    // clock edges in a segment: two per beat, beat is w bits
    function automatic logic [6:0] seg_edges(input logic [5:0] bits, input logic [2:0] w);
        case (w)
            3'h4:    seg_edges = {2'h0, bits[5:1]};
            3'h2:    seg_edges = {1'b0, bits};
            default: seg_edges = {bits, 1'b0};
        endcase
    endfunction

    function automatic logic [31:0] align(input logic [31:0] d, input logic [1:0] len);
        case (len)
            qsph_pkg::LEN_8:  align = {d[7:0], 24'h0};
            qsph_pkg::LEN_16: align = {d[15:0], 16'h0};
            default:          align = d;
        endcase
    endfunction

    // ----------------------------------------
    // transmit fifo
    // ----------------------------------------
    qsph_fifo_if #(.W(qsph_pkg::WORD_W)) ff ();

    qsph_fifo #(
        .WIDTH (qsph_pkg::WORD_W),
        .DEPTH (qsph_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .f       (ff.store)
    );

    logic        pop;
    logic        land;
    logic        tick;
    logic        last;
    logic        cap;
    logic        shf;
    logic [2:0]  w;
    logic [3:0]  din;
    logic [31:0] rx_new;
    logic [31:0] rx_word;
    logic [5:0]  bits;

    assign ff.push_valid = i_tx_valid && s.en && !s.software_reset_bit;
    assign ff.push_data  = i_tx_data;
    assign ff.pop_ready  = pop;
    assign ff.clear      = s.software_reset_bit;
    assign o_tx_ready    = ff.push_ready && s.en && !s.software_reset_bit;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.xipv = 1'b0;
        pop  = 1'b0;
        land = 1'b0;
        w    = seg_w(s.seg, s.lanes);
        case (s.seg)
            qsph_pkg::SEG_SPI:   bits = len_bits(s.len);
            qsph_pkg::SEG_INSTR: bits = qsph_pkg::BITS_8;
            qsph_pkg::SEG_ADDR:  bits = s.a32 ? qsph_pkg::BITS_32 : qsph_pkg::BITS_24;
            default:             bits = qsph_pkg::BITS_32;
        endcase
        // divider tick; no halt input, so debug and sleep never freeze it
        tick = s.div >= ((s.baud == 8'h0) ? 8'h0 : s.baud - 8'h1);
        last = s.hcnt == seg_edges(bits, w) - 7'h1;
        // even edge leads, odd edge trails
        cap  = s.cpha ? s.hcnt[0] : !s.hcnt[0];
        shf  = s.cpha ? (!s.hcnt[0] && s.hcnt != 7'h0) : s.hcnt[0];
        din  = (w == 3'h1) ? {3'h0, i_dio[1]} : (i_dio & ((4'h1 << w) - 4'h1));
        rx_new = (s.rx << w) | {28'h0, din};
        // with phase zero the last edge trails, so no bit may be taken there
        rx_word = cap ? rx_new : s.rx;
        if (i_cfg_wr && (!i_protect_on || i_debugger_access)) begin
            next_s.len   = i_word_len;
            next_s.lanes = i_lanes;
            next_s.mem   = i_mem_mode;
            next_s.a32   = i_addr32;
            next_s.cpol  = i_cpol;
            next_s.cpha  = i_cpha;
            next_s.baud  = i_baud_div;
            next_s.bct   = i_inter_transfer_delay;
            next_s.bs    = i_clock_start_delay;
            next_s.dcs   = i_select_inactive_delay;
        end
        if (i_enable_wr) begin
            next_s.en = i_enable_val;
        end
        if (ff.push_valid && ff.push_ready) begin
            next_s.tx_empty = 1'b0;
        end
        if (i_rx_read) begin
            next_s.rx_full = 1'b0;
        end
        if (i_error_clr) begin
            next_s.ovr = 1'b0;
        end
        if (i_complete_clr) begin
            next_s.tx_done = 1'b0;
        end
        if (s.cs_n && s.csi != qsph_pkg::CSI_MAX) begin
            next_s.csi = s.csi + 8'h1;
        end
        case (s.st)
            qsph_pkg::st_idle: begin
                next_s.sck = next_s.cpol;
                if (s.en && s.csi >= s.dcs) begin
                    if (!s.mem && ff.pop_valid) begin
                        pop        = 1'b1;
                        next_s.sh  = align(ff.pop_data, s.len);
                        next_s.seg = qsph_pkg::SEG_SPI;
                    end else if (s.mem && i_xip_req) begin
                        next_s.sh  = {i_xip_instr, 24'h0};
                        next_s.seg = qsph_pkg::SEG_INSTR;
                    end
                    if (pop || (s.mem && i_xip_req)) begin
                        next_s.cs_n = 1'b0;
                        next_s.dly  = s.bs;
                        next_s.st   = qsph_pkg::st_lead;
                    end
                end
            end
            qsph_pkg::st_lead: begin
                if (s.dly == 8'h0) begin
                    next_s.st   = qsph_pkg::st_shift;
                    next_s.div  = 8'h0;
                    next_s.hcnt = 7'h0;
                    next_s.rx   = 32'h0;
                end else begin
                    next_s.dly = s.dly - 8'h1;
                end
            end
            qsph_pkg::st_shift: begin
                if (!tick) begin
                    next_s.div = s.div + 8'h1;
                end else begin
                    next_s.div  = 8'h0;
                    next_s.sck  = !s.sck;
                    next_s.hcnt = s.hcnt + 7'h1;
                    if (cap) begin
                        next_s.rx = rx_new;
                    end
                    if (shf) begin
                        next_s.sh = s.sh << w;
                    end
                    if (last) begin
                        next_s.hcnt = 7'h0;
                        next_s.rx   = 32'h0;
                        case (s.seg)
                            qsph_pkg::SEG_SPI: begin
                                land       = 1'b1;
                                next_s.dly = s.bct;
                                next_s.st  = qsph_pkg::st_gap;
                            end
                            qsph_pkg::SEG_INSTR: begin
                                next_s.seg = qsph_pkg::SEG_ADDR;
                                next_s.sh  = s.a32 ? i_xip_addr : {i_xip_addr[23:0], 8'h0};
                            end
                            qsph_pkg::SEG_ADDR: begin
                                next_s.seg = qsph_pkg::SEG_DATA;
                            end
                            default: begin
                                next_s.xipd = rx_word;
                                next_s.xipv = 1'b1;
                                next_s.cs_n = 1'b1;
                                next_s.csi  = 8'h0;
                                next_s.st   = qsph_pkg::st_idle;
                            end
                        endcase
                    end
                end
            end
            default: begin
                if (s.dly != 8'h0) begin
                    next_s.dly = s.dly - 8'h1;
                end else if (s.en && ff.pop_valid) begin
                    // back to back words keep the select low
                    pop         = 1'b1;
                    next_s.sh   = align(ff.pop_data, s.len);
                    next_s.st   = qsph_pkg::st_shift;
                    next_s.div  = 8'h0;
                end else begin
                    next_s.cs_n    = 1'b1;
                    next_s.csi     = 8'h0;
                    next_s.tx_done = 1'b1;
                    next_s.st      = qsph_pkg::st_idle;
                end
            end
        endcase
        if (pop) begin
            next_s.tx_empty = 1'b1;
        end
        if (land) begin
            // the word lands even on overrun; the older one is lost
            next_s.rxd     = rx_word;
            next_s.rx_full = 1'b1;
            if (s.rx_full && !i_rx_read) begin
                next_s.ovr = 1'b1;
            end
        end
        if (i_software_reset_bit_wr && !s.software_reset_bit) begin
            next_s.software_reset_bit = 1'b1;
        end
        if (s.software_reset_bit) begin
            next_s = S_RST;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_enabled                = s.en;
    assign o_software_reset_bit     = s.software_reset_bit;
    assign o_rx_data                = s.rxd;
    assign o_transmit_empty_flag    = s.tx_empty;
    assign o_transmit_complete_flag = s.tx_done;
    assign o_receive_full_flag      = s.rx_full;
    assign o_overrun_flag           = s.ovr;
    assign o_tx_dma_req             = s.tx_empty;
    assign o_rx_dma_req             = s.rx_full;
    assign o_xip_ready = s.st == qsph_pkg::st_idle && s.en && s.mem
                         && s.csi >= s.dcs && !s.software_reset_bit;
    assign o_xip_data  = s.xipd;
    assign o_xip_valid = s.xipv;
    assign o_sck       = s.sck;
    assign o_cs_n      = s.cs_n;
    // lane 0 always drives in one-lane mode; read segments release the lanes
    always_comb begin
        case (w)
            3'h4: begin
                o_dio      = s.sh[31:28];
                o_dio_oe_n = (s.seg == qsph_pkg::SEG_DATA) ? 4'hf : 4'h0;
            end
            3'h2: begin
                o_dio      = {2'h0, s.sh[31:30]};
                o_dio_oe_n = (s.seg == qsph_pkg::SEG_DATA) ? 4'hf : 4'hc;
            end
            default: begin
                o_dio      = {3'h0, s.sh[31]};
                o_dio_oe_n = 4'he;
            end
        endcase
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    sequence software_reset_bit_req_s;
        i_software_reset_bit_wr && !o_software_reset_bit;
    endsequence
    sequence reset_seen_s;
        o_software_reset_bit ##1 (!o_software_reset_bit && o_enabled && o_cs_n);
    endsequence

    software_reset_bit_clear_a: assert property (
        software_reset_bit_req_s |=> reset_seen_s
    ) else $error("software reset did not complete and clear");
    enable_write_a: assert property (
        (i_enable_wr && !i_software_reset_bit_wr && !s.software_reset_bit) |=> (o_enabled == $past(i_enable_val))
    ) else $error("enable write not applied");
    tx_empty_a: assert property (
        (pop && !s.software_reset_bit) |=> o_transmit_empty_flag && o_tx_dma_req
    ) else $error("transmit empty not set on load");
    rx_land_a: assert property (
        (land && !s.software_reset_bit) |=> (o_receive_full_flag && o_rx_data == $past(rx_word))
    ) else $error("received word not landed");
    overrun_flag_a: assert property (
        (land && s.rx_full && !i_rx_read && !s.software_reset_bit) |=> o_overrun_flag
    ) else $error("overrun not flagged");
    lead_delay_a: assert property (
        $fell(o_cs_n) |-> (s.st == qsph_pkg::st_lead && s.dly == s.bs && o_sck == s.cpol)
    ) else $error("select asserted without start delay");
    cs_gap_a: assert property (
        $fell(o_cs_n) |-> ($past(s.csi) >= $past(s.dcs))
    ) else $error("select inactive time too short");
    done_delay_a: assert property (
        $rose(o_transmit_complete_flag) |-> $past(s.st == qsph_pkg::st_gap && s.dly == 8'h0)
    ) else $error("transmit complete before delay ended");
    idle_clock_a: assert property (
        (s.st != qsph_pkg::st_shift) |-> (o_sck == s.cpol)
    ) else $error("serial clock not at idle level");
    word_len_a: assert property (
        land |-> (s.hcnt + 7'h1 == {len_bits(s.len), 1'b0})
    ) else $error("word length mismatch");
endmodule

/* inc/qsph_fifo_if.sv */
interface qsph_fifo_if #(parameter int W = 32);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;
    logic         clear;
    modport owner (output push_valid, push_data, pop_ready, clear,
                   input  push_ready, pop_valid, pop_data);
    modport store (input  push_valid, push_data, pop_ready, clear,
                   output push_ready, pop_valid, pop_data);
endinterface

/* inc/qsph_pkg.sv */
package qsph_pkg;
    // ----------------------------------------
    // field codes
    // ----------------------------------------
    localparam logic [1:0] LEN_8     = 2'h0;
    localparam logic [1:0] LEN_16    = 2'h1;
    localparam logic [1:0] LEN_32    = 2'h2;
    localparam logic [1:0] LANE_1    = 2'h0;
    localparam logic [1:0] LANE_2    = 2'h1;
    localparam logic [1:0] LANE_4    = 2'h2;
    localparam logic [1:0] SEG_SPI   = 2'h0;
    localparam logic [1:0] SEG_INSTR = 2'h1;
    localparam logic [1:0] SEG_ADDR  = 2'h2;
    localparam logic [1:0] SEG_DATA  = 2'h3;
    // ----------------------------------------
    // counts and reset values
    // ----------------------------------------
    localparam logic [5:0] BITS_8    = 6'h08;
    localparam logic [5:0] BITS_16   = 6'h10;
    localparam logic [5:0] BITS_24   = 6'h18;
    localparam logic [5:0] BITS_32   = 6'h20;
    localparam logic       RST_EN    = 1'b1;
    localparam logic [7:0] RST_BAUD  = 8'h01;
    localparam logic [7:0] CSI_MAX   = 8'hff;
    localparam int         FIFO_DEPTH = 8;
    localparam int         WORD_W     = 32;
    // ----------------------------------------
    // states
    // ----------------------------------------
    typedef enum logic [1:0] {
        st_idle,
        st_lead,
        st_shift,
        st_gap
    } qsph_state_t;
endpackage
